// ---- shared/clkgen_pkg.sv ----
// constants and types shared by the cpu clock generator control block
// assumes a single 200 MHz system clock and oscillators sampled as levels
package clkgen_pkg;
	// ****************************************
	// register addresses and reset values
	// ****************************************
	localparam logic [15:0] SUBCLOCK_MULTIPLIER_SELECT_ADDR = 16'hff78;
	localparam logic [15:0] PROCESSOR_CLOCK_CONTROL_ADDR = 16'hfffb;
	localparam logic [7:0] PROCESSOR_CLOCK_CONTROL_RESET = 8'h04;
	localparam logic [7:0] SUBCLOCK_MULTIPLIER_SELECT_RESET = 8'h00;
	localparam logic [7:0] READ_IDLE = 8'h00;
	// ****************************************
	// field positions
	// ****************************************
	localparam int MAIN_OSC_STOP_BIT = 7;
	localparam int FEEDBACK_RESISTOR_DISABLE_BIT = 6;
	localparam int CPU_CLOCK_STATUS_BIT = 5;
	localparam int CLOCK_SOURCE_SELECT_BIT = 4;
	localparam int CPU_DIVIDER_LSB = 0;
	localparam int CPU_DIVIDER_MSB = 2;
	localparam int MULTIPLIER_ENABLE_BIT = 0;
	localparam int CPU_DIVIDER_W = 3;
	// ****************************************
	// divider codes and timing
	// ****************************************
	localparam logic [CPU_DIVIDER_W-1:0] DIV_BY_1 = 3'h0;
	localparam logic [CPU_DIVIDER_W-1:0] DIV_BY_16 = 3'h4;
	localparam int DIV_CNT_W = 4;
	localparam int SWITCH_DELAY_INSTR = 4;
	localparam int CPU_CLOCKS_PER_INSTR = 2;
	localparam int MULT_FACTOR = 4;
	localparam real CLK_PERIOD_NS = 5.0;
	typedef enum logic [0:0] {
		SW_STEADY = 1'b0,
		SW_PENDING = 1'b1
	} sw_state_e;
endpackage

// ---- design/clk_prescaler.sv ----
// power-of-two tick divider for the main clock path
// assumes src_tick is a one-cycle pulse per main oscillator rising edge
`timescale 1ns/10ps
module clk_prescaler (
	input wire logic clk,
	input wire logic reset,
	input wire logic src_tick,
	input wire logic [clkgen_pkg::CPU_DIVIDER_W-1:0] shift,
	output logic out_tick
);
	import clkgen_pkg::*;
	logic [DIV_CNT_W-1:0] cnt_ff;
	logic out_tick_ff;
	logic [DIV_CNT_W:0] mask_wide;
	logic [DIV_CNT_W-1:0] mask;
	logic [DIV_CNT_W-1:0] eff_shift;
	logic hit;
	// ****************************************
	// divide select
	// ****************************************
	// prohibited codes fall back to the slowest ratio
	assign eff_shift = (shift > DIV_BY_16) ? DIV_CNT_W'(DIV_BY_16) : DIV_CNT_W'(shift);
	assign mask_wide = (DIV_CNT_W+1)'((5'h01 << eff_shift) - 5'h01);
	assign mask = mask_wide[DIV_CNT_W-1:0];
	assign hit = src_tick & ((cnt_ff & mask) == mask);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= '0;
			out_tick_ff <= 1'b0;
		end else begin
			cnt_ff <= src_tick ? DIV_CNT_W'(cnt_ff + 1'b1) : cnt_ff;
			out_tick_ff <= hit;
		end
	end
	assign out_tick = out_tick_ff;
endmodule

// ---- design/cpu_clock_generator_control.sv ----
// cpu clock generator control: clock select, prescaler, x4 subclock, oscillator stop
// assumes oscillator outputs, stop and halt are synchronous levels on clk
`timescale 1ns/10ps
// Notes on behaviour
// - reset loads clock control with 04h: main clock divided by sixteen.
// - bit 7 set stops the main oscillator, clear lets it run.
// - bit 5 is read-only: 0 on main clock, 1 on subsystem clock.
// - source 0: divider codes 0 to 4 give main clock over 1,2,4,8,16.
// - source 1: cpu clock is subclock over two, or twice subclock multiplied.
// - fastest instruction takes two cpu clock periods.
// - subclock select clears to 00h only on reset, otherwise retained.
// - multiplier enable bit chooses source or times-four subclock for cpu path.
// - only first multiplier write after reset counts, made before source select.
// - multiplier stopped for the whole halt period.
// - after halt with multiplier on, wait one subclock period before resuming; the code resumes one cycle after the next subclock rising edge.
// - no way exists to stop the subsystem oscillator.
// - main oscillator stops on stop instruction or stop bit.
// - after a clock selection write, old clock runs several instructions.
// - stop bit acts only once the cpu has switched to subsystem clock.
// - main oscillation halted while reset is applied.
module cpu_clock_generator_control #(
	parameter int PERIOD_W = 16,
	parameter int SWITCH_DELAY = clkgen_pkg::SWITCH_DELAY_INSTR * clkgen_pkg::CPU_CLOCKS_PER_INSTR
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_wr,
	input wire logic mem_rd,
	output logic [7:0] mem_rdata,
	input wire logic main_osc_in,
	input wire logic sub_osc_in,
	input wire logic stop_instr,
	input wire logic halt_in,
	output logic cpu_clk_tick,
	output logic instr_tick,
	output logic periph_main_tick,
	output logic main_osc_halt,
	output logic feedback_resistor_disable,
	output logic multiplier_active,
	output logic cpu_clock_status
);
	import clkgen_pkg::*;
	// ****************************************
	// register file
	// ****************************************
	logic main_osc_stop_ff, frd_ff, css_ff, sct_ff, sct_locked_ff;
	logic [CPU_DIVIDER_W-1:0] div_ff;
	logic [7:0] rdata_ff;
	wire hit_pcc = (mem_addr == PROCESSOR_CLOCK_CONTROL_ADDR);
	wire hit_subclock_multiplier_select = (mem_addr == SUBCLOCK_MULTIPLIER_SELECT_ADDR);
	wire wr_pcc = mem_wr & hit_pcc;
	wire wr_subclock_multiplier_select = mem_wr & hit_subclock_multiplier_select;
	logic css_active_ff;
	logic [CPU_DIVIDER_W-1:0] div_active_ff;
	// reserved bit 3 and bits 7..1 of subclock select read as zero
	wire [7:0] pcc_view = {main_osc_stop_ff, frd_ff, css_active_ff, css_ff, 1'b0, div_ff};
	wire [7:0] subclock_multiplier_select_view = {7'h00, sct_ff};
	wire [7:0] nxt_rdata = !mem_rd ? READ_IDLE : hit_pcc ? pcc_view : hit_subclock_multiplier_select ? subclock_multiplier_select_view : READ_IDLE;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			main_osc_stop_ff <= PROCESSOR_CLOCK_CONTROL_RESET[MAIN_OSC_STOP_BIT];
			frd_ff <= PROCESSOR_CLOCK_CONTROL_RESET[FEEDBACK_RESISTOR_DISABLE_BIT];
			css_ff <= PROCESSOR_CLOCK_CONTROL_RESET[CLOCK_SOURCE_SELECT_BIT];
			div_ff <= PROCESSOR_CLOCK_CONTROL_RESET[CPU_DIVIDER_MSB:CPU_DIVIDER_LSB];
		end else if (wr_pcc) begin
			main_osc_stop_ff <= mem_wdata[MAIN_OSC_STOP_BIT];
			frd_ff <= mem_wdata[FEEDBACK_RESISTOR_DISABLE_BIT];
			css_ff <= mem_wdata[CLOCK_SOURCE_SELECT_BIT];
			div_ff <= mem_wdata[CPU_DIVIDER_MSB:CPU_DIVIDER_LSB];
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sct_ff <= SUBCLOCK_MULTIPLIER_SELECT_RESET[MULTIPLIER_ENABLE_BIT];
			sct_locked_ff <= 1'b0;
		end else if (wr_subclock_multiplier_select && !sct_locked_ff) begin
			sct_ff <= mem_wdata[MULTIPLIER_ENABLE_BIT];
			sct_locked_ff <= 1'b1;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_ff <= READ_IDLE;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end
	// ****************************************
	// oscillator edge detection
	// ****************************************
	logic main_prev_ff, sub_prev_ff, halt_prev_ff, main_osc_halt_ff;
	wire main_tick = main_osc_in & ~main_prev_ff & ~main_osc_halt_ff;
	wire sub_tick = sub_osc_in & ~sub_prev_ff;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			main_prev_ff <= 1'b0;
			sub_prev_ff <= 1'b0;
			halt_prev_ff <= 1'b0;
		end else begin
			main_prev_ff <= main_osc_in;
			sub_prev_ff <= sub_osc_in;
			halt_prev_ff <= halt_in;
		end
	end
	// ****************************************
	// times-four subclock multiplier
	// ****************************************
	// period is measured in system cycles, so the first period after reset has no quarters
	logic [PERIOD_W-1:0] sub_cnt_ff, period_ff, q_cnt_ff;
	logic [1:0] q_num_ff;
	logic halt_wait_ff;
	wire [PERIOD_W-1:0] quarter = period_ff >> 2;
	wire mult_run = sct_ff & ~halt_in & ~halt_prev_ff & ~halt_wait_ff;
	wire quarter_hit = mult_run & ~sub_tick & (quarter != '0) & (q_cnt_ff == PERIOD_W'(quarter - 1'b1))
		& (q_num_ff != 2'(MULT_FACTOR - 1));
	wire mult_tick = mult_run & (sub_tick | quarter_hit);
	wire halt_release = halt_prev_ff & ~halt_in & sct_ff;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sub_cnt_ff <= '0;
			period_ff <= '0;
		end else if (sub_tick) begin
			sub_cnt_ff <= '0;
			period_ff <= PERIOD_W'(sub_cnt_ff + 1'b1);
		end else begin
			sub_cnt_ff <= PERIOD_W'(sub_cnt_ff + 1'b1);
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q_cnt_ff <= '0;
			q_num_ff <= '0;
		end else if (sub_tick) begin
			q_cnt_ff <= '0;
			q_num_ff <= '0;
		end else if (quarter_hit) begin
			q_cnt_ff <= '0;
			q_num_ff <= 2'(q_num_ff + 1'b1);
		end else begin
			q_cnt_ff <= PERIOD_W'(q_cnt_ff + 1'b1);
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			halt_wait_ff <= 1'b0;
		end else if (halt_release) begin
			halt_wait_ff <= 1'b1;
		end else if (sub_tick) begin
			halt_wait_ff <= 1'b0;
		end
	end
	// ****************************************
	// cpu clock paths
	// ****************************************
	logic sub_half_ff, main_cpu_tick, cpu_tick_ff, instr_phase_ff, instr_tick_ff;
	wire sub_path_tick = sct_ff ? mult_tick : sub_tick;
	wire sub_cpu_tick = sub_path_tick & sub_half_ff;
	wire cpu_tick = css_active_ff ? sub_cpu_tick : main_cpu_tick;
	clk_prescaler u_prescaler (
		.clk(clk),
		.reset(reset),
		.src_tick(main_tick),
		.shift(div_active_ff),
		.out_tick(main_cpu_tick)
	);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sub_half_ff <= 1'b0;
			cpu_tick_ff <= 1'b0;
			instr_phase_ff <= 1'b0;
			instr_tick_ff <= 1'b0;
		end else begin
			sub_half_ff <= sub_path_tick ? ~sub_half_ff : sub_half_ff;
			cpu_tick_ff <= cpu_tick;
			instr_phase_ff <= cpu_tick ? ~instr_phase_ff : instr_phase_ff;
			instr_tick_ff <= cpu_tick & instr_phase_ff;
		end
	end
	// ****************************************
	// delayed switchover
	// ****************************************
	sw_state_e sw_state_ff, nxt_sw_state;
	logic [7:0] dly_cnt_ff;
	wire sel_differs = (css_ff != css_active_ff) | (div_ff != div_active_ff);
	wire dly_done = cpu_tick & (dly_cnt_ff == 8'(SWITCH_DELAY - 1));
	always_comb begin
		nxt_sw_state = sw_state_ff;
		case (sw_state_ff)
			SW_STEADY: begin
				if (sel_differs) begin
					nxt_sw_state = SW_PENDING;
				end
			end
			SW_PENDING: begin
				if (dly_done) begin
					nxt_sw_state = SW_STEADY;
				end
			end
			default: nxt_sw_state = SW_STEADY;
		endcase
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sw_state_ff <= SW_STEADY;
			dly_cnt_ff <= '0;
			css_active_ff <= PROCESSOR_CLOCK_CONTROL_RESET[CLOCK_SOURCE_SELECT_BIT];
			div_active_ff <= PROCESSOR_CLOCK_CONTROL_RESET[CPU_DIVIDER_MSB:CPU_DIVIDER_LSB];
		end else begin
			sw_state_ff <= nxt_sw_state;
			dly_cnt_ff <= (sw_state_ff != SW_PENDING || dly_done) ? 8'h00 : cpu_tick ? 8'(dly_cnt_ff + 1'b1) : dly_cnt_ff;
			if (sw_state_ff == SW_PENDING && dly_done) begin
				css_active_ff <= css_ff;
				div_active_ff <= div_ff;
			end
		end
	end
	// ****************************************
	// oscillator stop
	// ****************************************
	// stop instruction or bit
	wire nxt_main_osc_halt = stop_instr | (main_osc_stop_ff & css_active_ff);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			main_osc_halt_ff <= 1'b1;
		end else begin
			main_osc_halt_ff <= nxt_main_osc_halt;
		end
	end
	assign mem_rdata = rdata_ff;
	assign cpu_clk_tick = cpu_tick_ff;
	assign instr_tick = instr_tick_ff;
	assign periph_main_tick = main_cpu_tick;
	assign main_osc_halt = main_osc_halt_ff;
	assign feedback_resistor_disable = frd_ff;
	assign multiplier_active = mult_run;
	assign cpu_clock_status = css_active_ff;
	// ****************************************
	// assertions
	// ****************************************
	status_at_tick_a: assert property (@(posedge clk) disable iff (reset)
		$changed(css_active_ff) |-> $past(cpu_tick)) else $error("status changed off a cpu tick");
	switch_wait_a: assert property (@(posedge clk) disable iff (reset)
		$changed(css_active_ff) |-> $past(sw_state_ff == SW_PENDING && dly_cnt_ff == 8'(SWITCH_DELAY - 1)))
		else $error("switch without the delay");
	main_stop_a: assert property (@(posedge clk) disable iff (reset)
		main_osc_halt_ff && !$past(stop_instr) && !$past(reset) |-> $past(main_osc_stop_ff && css_active_ff))
		else $error("main oscillator stopped on main clock");
	stop_instr_a: assert property (@(posedge clk) disable iff (reset)
		stop_instr |=> main_osc_halt_ff) else $error("stop did not halt oscillator");
	mult_halt_a: assert property (@(posedge clk) disable iff (reset)
		halt_in |-> !multiplier_active && !(sct_ff && css_active_ff && cpu_tick)) else $error("multiplier ran in halt");
	halt_resume_a: assert property (@(posedge clk) disable iff (reset)
		$fell(halt_in) && sct_ff |-> !multiplier_active ##1 !multiplier_active)
		else $error("multiplier resumed without waiting");
	sct_lock_a: assert property (@(posedge clk) disable iff (reset)
		sct_locked_ff && wr_subclock_multiplier_select |=> $stable(sct_ff)) else $error("late multiplier write took effect");
	subclock_multiplier_select_retain_a: assert property (@(posedge clk) disable iff (reset)
		!wr_subclock_multiplier_select |=> $stable(sct_ff)) else $error("subclock select changed without write");
	status_read_a: assert property (@(posedge clk) disable iff (reset)
		mem_rd && hit_pcc |=> mem_rdata[CPU_CLOCK_STATUS_BIT] == $past(css_active_ff) && !mem_rdata[3])
		else $error("status read mismatch");
	div1_path_a: assert property (@(posedge clk) disable iff (reset)
		main_tick && !css_active_ff && div_active_ff == DIV_BY_1 && $stable(div_active_ff) |-> ##2 cpu_clk_tick)
		else $error("undivided main clock lost a tick");
	instr_pair_a: assert property (@(posedge clk) disable iff (reset)
		instr_tick |-> cpu_clk_tick) else $error("instruction slot off a cpu tick");
	sub_switch_c: cover property (@(posedge clk) disable iff (reset) $rose(css_active_ff));
	main_switch_c: cover property (@(posedge clk) disable iff (reset) $fell(css_active_ff));
	halt_exit_c: cover property (@(posedge clk) disable iff (reset) halt_release ##[1:1000] $fell(halt_wait_ff));
	osc_stop_c: cover property (@(posedge clk) disable iff (reset) $rose(main_osc_halt_ff) && !stop_instr);
endmodule

// ---- testbench/osc_partner.sv ----
// oscillator model feeding the clock generator control block
// assumes outputs are sampled on the rising edge of the 200 MHz clk
`timescale 1ns/10ps
module osc_partner #(
	parameter int MAIN_HALF = 4,
	parameter int SUB_HALF = 64
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic main_osc_halt,
	output logic main_osc_in,
	output logic sub_osc_in
);
	int main_cnt_ff = 0;
	int sub_cnt_ff = 0;
	logic main_lvl_ff = 1'b0;
	logic sub_lvl_ff = 1'b0;
	assign main_osc_in = main_lvl_ff;
	assign sub_osc_in = sub_lvl_ff;
	// crystal model, not an external clock, so stopping is legal
	// a halted crystal gives no edges, so the line sits low
	always @(posedge clk or posedge reset) begin
		if (reset || main_osc_halt) begin
			main_cnt_ff <= 0;
			main_lvl_ff <= 1'b0;
		end else if (main_cnt_ff == MAIN_HALF - 1) begin
			main_cnt_ff <= 0;
			main_lvl_ff <= ~main_lvl_ff;
		end else begin
			main_cnt_ff <= main_cnt_ff + 1;
		end
	end
	// subsystem oscillator
	// no reset and no stop input: it runs from power up
	always @(posedge clk) begin
		if (sub_cnt_ff == SUB_HALF - 1) begin
			sub_cnt_ff <= 0;
			sub_lvl_ff <= ~sub_lvl_ff;
		end else begin
			sub_cnt_ff <= sub_cnt_ff + 1;
		end
	end
endmodule

// ---- testbench/cpu_clock_generator_control_bench.sv ----
// self-checking bench for the cpu clock generator control block
// assumes main oscillator period 8 clk and subsystem period 128 clk from osc_partner
`timescale 1ns/10ps
`define CHECK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module cpu_clock_generator_control_bench;
	import clkgen_pkg::*;
	// ****************************************
	// stimulus and design
	// ****************************************
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] mem_addr = 16'h0000;
	logic [7:0] mem_wdata = 8'h00;
	logic mem_wr = 1'b0;
	logic mem_rd = 1'b0;
	logic stop_instr = 1'b0;
	logic halt_in = 1'b0;
	logic [7:0] mem_rdata, rdv;
	logic main_osc_in, sub_osc_in, cpu_clk_tick, instr_tick, periph_main_tick, main_osc_halt;
	logic feedback_resistor_disable, multiplier_active, cpu_clock_status;
	logic [6:0] watch;
	int n_fail = 0;
	int n_compared = 0;
	int cnt;
	localparam logic [15:0] PCC_A = PROCESSOR_CLOCK_CONTROL_ADDR;
	localparam logic [15:0] SEL_A = SUBCLOCK_MULTIPLIER_SELECT_ADDR;
	always #2.5 clk = ~clk;
	assign watch = {periph_main_tick, sub_osc_in, ~sub_osc_in, multiplier_active, cpu_clock_status, instr_tick,
		cpu_clk_tick};
	// small switch delay keeps the run short; expectations use 2
	cpu_clock_generator_control #(.SWITCH_DELAY(2)) dut (.clk(clk), .reset(reset), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
		.main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in), .stop_instr(stop_instr), .halt_in(halt_in),
		.cpu_clk_tick(cpu_clk_tick), .instr_tick(instr_tick), .periph_main_tick(periph_main_tick),
		.main_osc_halt(main_osc_halt), .feedback_resistor_disable(feedback_resistor_disable),
		.multiplier_active(multiplier_active), .cpu_clock_status(cpu_clock_status));
	osc_partner #(.MAIN_HALF(4), .SUB_HALF(64)) partner (.clk(clk), .reset(reset),
		.main_osc_halt(main_osc_halt), .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in));
	// ****************************************
	// tasks
	// ****************************************
	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		mem_addr = a;
		mem_wdata = d;
		mem_wr = 1'b1;
		@(negedge clk);
		mem_wr = 1'b0;
	endtask
	// read data is registered, so it is settled at the following falling edge
	task automatic chk_rd(input logic [15:0] a, input logic [7:0] e, input string nm);
		@(negedge clk);
		mem_addr = a;
		mem_rd = 1'b1;
		@(negedge clk);
		mem_rd = 1'b0;
		rdv = mem_rdata;
		`CHECK(nm, e, rdv)
	endtask
	// bounded wait for one watched signal; a hang ends the run
	task automatic wait_on(input int sel, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (watch[sel] !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			n_fail++;
			give_verdict();
		end
	endtask
	task automatic period(input int sel, input int e, input string nm);
		int n;
		wait_on(sel, n);
		wait_on(sel, n);
		`CHECK(nm, e, n)
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (6) @(negedge clk);
		`CHECK("osc halt in reset", 1'b1, main_osc_halt)
		reset = 1'b0;
		chk_rd(PCC_A, 8'h04, "clock control reset");
		chk_rd(SEL_A, 8'h00, "subclock select reset");
		chk_rd(16'hff79, 8'h00, "unmapped read");
		wr(PCC_A, 8'h64);
		chk_rd(PCC_A, 8'h44, "status bit read only");
		`CHECK("feedback output", 1'b1, feedback_resistor_disable)
		$display("register test done");
		for (int k = 0; k < 5; k++) begin
			wr(PCC_A, k[7:0]);
			repeat (3) wait_on(0, cnt);
			period(0, 8 << k, "cpu tick period");
			period(1, 16 << k, "instruction period");
			period(6, 8 << k, "peripheral tick period");
		end
		$display("divider test done");
		wr(PCC_A, 8'h80);
		repeat (20) @(negedge clk);
		`CHECK("stop bit on main clock", 1'b0, main_osc_halt)
		wr(PCC_A, 8'h00);
		stop_instr = 1'b1;
		repeat (3) @(negedge clk);
		`CHECK("stop instruction", 1'b1, main_osc_halt)
		stop_instr = 1'b0;
		repeat (3) @(negedge clk);
		`CHECK("oscillation permitted", 1'b0, main_osc_halt)
		$display("oscillator stop test done");
		wr(SEL_A, 8'h01);
		wr(SEL_A, 8'h00);
		chk_rd(SEL_A, 8'h01, "first write kept");
		// main clock undivided (code 0) before the switch
		wr(PCC_A, 8'h10);
		chk_rd(PCC_A, 8'h10, "status before switch");
		wait_on(2, cnt);
		`CHECK("switch delay", 1'b1, cnt >= 10)
		chk_rd(PCC_A, 8'h30, "status after switch");
		repeat (3) wait_on(0, cnt);
		period(0, 64, "x4 cpu period");
		`CHECK("multiplier running", 1'b1, multiplier_active)
		halt_in = 1'b1;
		repeat (2) @(negedge clk);
		`CHECK("multiplier in halt", 1'b0, multiplier_active)
		wait_on(4, cnt);
		wait_on(5, cnt);
		halt_in = 1'b0;
		@(negedge clk);
		`CHECK("wait after halt", 1'b0, multiplier_active)
		wait_on(3, cnt);
		`CHECK("one sub period wait", 1'b1, cnt >= 100)
		$display("multiplier test done");
		// stop through the bit while on subsystem clock
		wr(PCC_A, 8'h90);
		repeat (3) @(negedge clk);
		`CHECK("stop bit on subclock", 1'b1, main_osc_halt)
		wr(PCC_A, 8'h10);
		@(negedge clk);
		`CHECK("stop bit cleared", 1'b0, main_osc_halt)
		reset = 1'b1;
		@(negedge clk);
		`CHECK("osc halt second reset", 1'b1, main_osc_halt)
		repeat (5) @(negedge clk);
		reset = 1'b0;
		chk_rd(SEL_A, 8'h00, "cleared by reset");
		// multiplier left off after reset: plain subclock over two
		wr(PCC_A, 8'h10);
		repeat (3) wait_on(0, cnt);
		period(0, 256, "plain sub cpu period");
		`CHECK("multiplier idle", 1'b0, multiplier_active)
		$display("second reset test done");
		give_verdict();
	end
endmodule
